/* verif/bpc_pin_env.sv */
// pin-side model of the port's outside world
`timescale 1ns/1ps
module bpc_pin_env (
    input wire [7:0] ext,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    output wire [7:0] pin_in
);
// a driven pin shows the port's value, an undriven one the outside level
assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule

/* verif/bpc_port_asserts.sv */
// checker for the bit port and command unit
`timescale 1ns/1ps
module bpc_chk (
    input wire clk,
    input wire resetn,
    input wire io_request_n,
    input wire port_cs_n,
    input wire cmd_cs_n,
    input wire rd_n,
    input wire dir_we,
    input wire [7:0] data_in,
    input wire [7:0] data_out,
    input wire data_oe,
    input wire [7:0] pin_in,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire serial_reset,
    input wire counter_reset,
    input wire parallel_reset,
    input wire route_serial,
    input wire [2:0] chain_pattern
);
wire rs = !io_request_n && !port_cs_n && !rd_n;
wire ws = !io_request_n && !port_cs_n && rd_n && !route_serial;
wire cw = !io_request_n && !cmd_cs_n && rd_n;
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
property p_rd; $rose(rs) |=> data_oe; endproperty
a_rd: assert property (p_rd) else $error("read not driven");
property p_rdat; $rose(rs) && !route_serial |=>
    data_out == (($past(pin_in) & ~$past(pin_oe)) | ($past(pin_out) & $past(pin_oe))); endproperty
a_rdat: assert property (p_rdat) else $error("read data wrong");
property p_wr; $rose(ws) && !dir_we |-> ##2 (pin_out & pin_oe) == ($past(data_in, 2) & pin_oe);
endproperty
a_wr: assert property (p_wr) else $error("latch not written");
property p_dir; $rose(ws) && dir_we |-> ##2 pin_oe == $past(data_in, 2); endproperty
a_dir: assert property (p_dir) else $error("direction not written");
property p_chain; $rose(cw) && data_in[3] |=> chain_pattern == $past(data_in[2:0]); endproperty
a_chain: assert property (p_chain) else $error("chain not updated");
property p_keep; $rose(cw) && !data_in[3] |=> $stable(chain_pattern); endproperty
a_keep: assert property (p_keep) else $error("chain changed");
property p_rst; $rose(cw) |=> serial_reset == $past(data_in[4]) ##1 !serial_reset; endproperty
a_rst: assert property (p_rst) else $error("serial reset pulse wrong");
property p_crst; $rose(cw) |=> counter_reset == $past(data_in[5]) ##1 !counter_reset; endproperty
a_crst: assert property (p_crst) else $error("counter reset pulse wrong");
property p_prst; $rose(cw) |=> parallel_reset == $past(data_in[6]) ##1 !parallel_reset;
endproperty
a_prst: assert property (p_prst) else $error("parallel reset pulse wrong");
property p_por; $rose(resetn) |-> pin_oe == 8'h00 && !data_oe; endproperty
a_por: assert property (p_por) else $error("reset state wrong");
cover property ($rose(rs));
cover property ($rose(cw) && data_in[3]);
cover property (route_serial);
endmodule
bind bpc_port bpc_chk chk (.*);

/* verif/testbench.sv */
// self-checking bench for the bit port and command unit
`timescale 1ns/1ps
`define CHK(n,e,a) begin total_checks++; if ((e) !== (a)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
reg clk = 0, resetn = 0, io_request_n = 1, port_cs_n = 1, cmd_cs_n = 1, rd_n = 1, dir_we = 0;
reg [7:0] data_in = 8'h00, ext = 8'h00, d, l, v, e;
reg [3:0] st = 4'h0;
reg [5:0] tbl [8] = '{6'h1B, 6'h1E, 6'h27, 6'h2D, 6'h36, 6'h39, 6'h00, 6'h00};
wire [7:0] data_out, pin_in, pin_out, pin_oe;
wire [2:0] chain_pattern;
wire [1:0] s1, s2, s3;
wire data_oe, route_serial;
int n_fail = 0, total_checks = 0, i;
reg [7:0] q [$];
reg was = 0;
always #50 clk = ~clk;
bpc_port uut (.clk(clk), .resetn(resetn), .io_request_n(io_request_n), .port_cs_n(port_cs_n),
    .cmd_cs_n(cmd_cs_n), .rd_n(rd_n), .dir_we(dir_we), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .dtr_a_state(st[3]),
    .rts_a_state(st[2]), .rts_b_state(st[1]), .dtr_b_state(st[0]), .serial_reset(),
    .counter_reset(), .parallel_reset(), .route_serial(route_serial),
    .chain_pattern(chain_pattern), .first_src(s1), .second_src(s2), .third_src(s3));
bpc_pin_env env (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
// select held two edges, then idle long enough for pins to settle
task bus(input c, input r, input w, input [7:0] x);
begin
    io_request_n <= 0;
    port_cs_n <= c;
    cmd_cs_n <= !c;
    rd_n <= r;
    dir_we <= w;
    data_in <= x;
    repeat (2) @(posedge clk);
    {io_request_n, port_cs_n, cmd_cs_n, rd_n} <= 4'hF;
    repeat (3) @(posedge clk);
end
endtask
task end_sim;
begin
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
end
endtask
always @(negedge clk)
begin
    if (data_oe === 1'b1 && !was)
    begin
        e = q.pop_front();
        `CHK("data_out", e, data_out)
    end
    was = data_oe === 1'b1;
end
initial
begin
    #100000;
    n_fail++;
    end_sim;
end
initial
begin
    i = $urandom(97717);
    repeat (16) @(posedge clk);
    resetn <= 1;
    ext <= $urandom;
    @(posedge clk);
    `CHK("pin_oe", 8'h00, pin_oe)
    q.push_back(ext);
    bus(0, 0, 0, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i++)
    begin
        d = $urandom;
        l = $urandom;
        ext <= $urandom;
        bus(0, 1, 1, d);
        bus(0, 1, 0, l);
        q.push_back((ext & ~d) | (l & d));
        bus(0, 0, 0, 8'h00);
    end
    $display("port test done");
    for (i = 0; i < 8; i++)
    begin
        v = {1'b0, 3'($urandom), 1'b1, 3'(i)};
        bus(1, 1, 0, v);
        `CHK("chain", v[2:0], chain_pattern)
        `CHK("order", tbl[i], {s1, s2, s3})
    end
    $display("chain test done");
    st <= $urandom;
    bus(1, 1, 0, 8'h80);
    `CHK("chain", 3'h7, chain_pattern)
    `CHK("routed oe", 4'hF, pin_oe[5:2])
    `CHK("routed pins", {st[3], ~st[2], ~st[1], st[0]}, pin_out[5:2])
    $display("route test done");
    end_sim;
end
endmodule

/* verilog/bpc_port.v */
// bit-programmable port with chip command unit
`timescale 1ns/1ps
`include "bpc_regs.vh"
module bpc_port #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire resetn,
    input wire io_request_n,
    input wire port_cs_n,
    input wire cmd_cs_n,
    input wire rd_n,
    input wire dir_we,
    input wire [WIDTH-1:0] data_in,
    output reg [WIDTH-1:0] data_out,
    output reg data_oe,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_out,
    output reg [WIDTH-1:0] pin_oe,
    input wire dtr_a_state,
    input wire dtr_b_state,
    input wire rts_a_state,
    input wire rts_b_state,
    output reg serial_reset,
    output reg counter_reset,
    output reg parallel_reset,
    output reg route_serial,
    output reg [2:0] chain_pattern,
    output reg [1:0] first_src,
    output reg [1:0] second_src,
    output reg [1:0] third_src
);
    // ==========================================
    // bus decode
    reg [WIDTH-1:0] dir_reg;
    reg [WIDTH-1:0] lat_reg;
    reg rd_seen_reg;
    reg wr_seen_reg;
    // own edge memory, so a held command select fires its reset pulses once
    reg cmd_seen_reg;
    wire port_rd = !io_request_n && !port_cs_n && !rd_n;
    wire port_wr = !io_request_n && !port_cs_n && rd_n;
    wire cmd_wr = !io_request_n && !cmd_cs_n && rd_n;
    wire [1:0] f_src;
    wire [1:0] s_src;
    wire [1:0] t_src;
    // 1 = output per bit
    wire [WIDTH-1:0] read_val = (lat_reg & dir_reg) | (pin_in & ~dir_reg);
    reg [WIDTH-1:0] mux_out;
    reg [WIDTH-1:0] mux_oe;
    integer i;

    bpc_prio_decode u_dec (
        .pattern(chain_pattern),
        .first_src(f_src),
        .second_src(s_src),
        .third_src(t_src)
    );

    // ==========================================
    // port data path
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            dir_reg <= `BPC_DIR_RESET;
            lat_reg <= `BPC_LAT_RESET;
            data_out <= {WIDTH{1'b0}};
            data_oe <= 1'b0;
            rd_seen_reg <= 1'b0;
            wr_seen_reg <= 1'b0;
        end
        else
        begin
            rd_seen_reg <= port_rd;
            wr_seen_reg <= port_wr;
            // sample once at the start of the cycle, then hold
            if (port_rd && !rd_seen_reg)
                data_out <= read_val;
            data_oe <= port_rd;
            if (port_wr && !wr_seen_reg)
            begin
                if (dir_we)
                    dir_reg <= data_in;
                else
                    lat_reg <= data_in;
            end
        end
    end

    // ==========================================
    // command unit
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            chain_pattern <= `BPC_CHAIN_RESET;
            route_serial <= 1'b0;
            serial_reset <= 1'b0;
            counter_reset <= 1'b0;
            parallel_reset <= 1'b0;
            first_src <= 2'h0;
            second_src <= 2'h0;
            third_src <= 2'h0;
            cmd_seen_reg <= 1'b0;
        end
        else
        begin
            cmd_seen_reg <= cmd_wr;
            serial_reset <= 1'b0;
            counter_reset <= 1'b0;
            parallel_reset <= 1'b0;
            first_src <= f_src;
            second_src <= s_src;
            third_src <= t_src;
            if (cmd_wr && !cmd_seen_reg)
            begin
                if (data_in[`BPC_CMD_CHAIN_WE])
                    chain_pattern <= data_in[`BPC_CMD_CHAIN_MSB:`BPC_CMD_CHAIN_LSB];
                serial_reset <= data_in[`BPC_CMD_RST_SER];
                counter_reset <= data_in[`BPC_CMD_RST_CTR];
                parallel_reset <= data_in[`BPC_CMD_RST_PAR];
                route_serial <= data_in[`BPC_CMD_ROUTE];
            end
        end
    end

    // ==========================================
    // pin mux; no handshake or interrupt logic on this port
    always @*
    begin
        mux_out = lat_reg;
        mux_oe = dir_reg;
        if (route_serial)
        begin
            mux_out[`BPC_BIT_DTR_A] = dtr_a_state;
            mux_out[`BPC_BIT_DTR_B] = dtr_b_state;
            mux_out[`BPC_BIT_RTS_A] = ~rts_a_state;
            mux_out[`BPC_BIT_RTS_B] = ~rts_b_state;
            for (i = `BPC_BIT_DTR_B; i <= `BPC_BIT_DTR_A; i = i + 1)
                mux_oe[i] = 1'b1;
        end
    end

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            pin_out <= {WIDTH{1'b0}};
            pin_oe <= {WIDTH{1'b0}};
        end
        else
        begin
            pin_out <= mux_out;
            pin_oe <= mux_oe;
        end
    end
endmodule

/* verilog/bpc_prio_decode.v */
// chain pattern to per-position source selection
`timescale 1ns/1ps
`include "bpc_regs.vh"
module bpc_prio_decode (
    input wire [2:0] pattern,
    output reg [1:0] first_src,
    output reg [1:0] second_src,
    output reg [1:0] third_src
);
    // sources: 1 serial, 2 counter, 3 parallel, 0 none
    always @*
    begin
        first_src = 2'h0;
        second_src = 2'h0;
        third_src = 2'h0;
        case (pattern)
            `BPC_ORD_SCP:
            begin
                first_src = 2'h1; second_src = 2'h2; third_src = 2'h3;
            end
            `BPC_ORD_SPC:
            begin
                first_src = 2'h1; second_src = 2'h3; third_src = 2'h2;
            end
            `BPC_ORD_CSP:
            begin
                first_src = 2'h2; second_src = 2'h1; third_src = 2'h3;
            end
            `BPC_ORD_CPS:
            begin
                first_src = 2'h2; second_src = 2'h3; third_src = 2'h1;
            end
            `BPC_ORD_PSC:
            begin
                first_src = 2'h3; second_src = 2'h1; third_src = 2'h2;
            end
            `BPC_ORD_PCS:
            begin
                first_src = 2'h3; second_src = 2'h2; third_src = 2'h1;
            end
            default:
            begin
                first_src = 2'h0; second_src = 2'h0; third_src = 2'h0;
            end
        endcase
    end
endmodule

/* verilog/bpc_regs.vh */
// constants for the bit port and command unit
`ifndef BPC_REGS_VH
`define BPC_REGS_VH
`define BPC_CMD_CHAIN_LSB 0
`define BPC_CMD_CHAIN_MSB 2
`define BPC_CMD_CHAIN_WE 3
`define BPC_CMD_RST_SER 4
`define BPC_CMD_RST_CTR 5
`define BPC_CMD_RST_PAR 6
`define BPC_CMD_ROUTE 7
`define BPC_CHAIN_RESET 3'h0
`define BPC_DIR_RESET 8'h00
`define BPC_LAT_RESET 8'h00
`define BPC_BIT_DTR_A 5
`define BPC_BIT_RTS_A 4
`define BPC_BIT_RTS_B 3
`define BPC_BIT_DTR_B 2
`define BPC_ORD_SCP 3'h0
`define BPC_ORD_SPC 3'h1
`define BPC_ORD_CSP 3'h2
`define BPC_ORD_CPS 3'h3
`define BPC_ORD_PSC 3'h4
`define BPC_ORD_PCS 3'h5
`define BPC_ORD_NONE 3'h6
`endif
